// *** sim/tcc_cpu_model.sv ***
`timescale 1ns/1ps
module tcc_cpu_model
(
    input  wire logic       core_clk,
    output logic      [3:0] bus_addr,
    output logic            bus_wr,
    output logic            bus_rd,
    output logic      [7:0] bus_wdata,
    input  wire logic [7:0] bus_rdata
);
    initial
    begin
        bus_addr = 4'h0;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        bus_wdata = 8'h00;
    end
    // Data is inverted after use so a stale byte never looks valid
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge core_clk);
        bus_wr <= 1'b0;
        bus_wdata <= ~d;
        @(negedge core_clk);
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge core_clk);
        bus_rd <= 1'b0;
        @(negedge core_clk);
        d = bus_rdata;
    endtask
    task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
        wr(lo + 4'h1, v[15:8]);
        wr(lo, v[7:0]);
    endtask
    task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
        rd(lo, v[7:0]);
        rd(lo + 4'h1, v[15:8]);
    endtask
endmodule

// *** sim/tcc_timer_sva.sv ***
`timescale 1ns/1ps
module tcc_timer_chk
(
    input wire logic       core_clk,
    input wire logic       rst_n,
    input wire logic [3:0] bus_addr,
    input wire logic       bus_wr,
    input wire logic       bus_rd,
    input wire logic [7:0] bus_wdata,
    input wire logic [7:0] bus_rdata,
    input wire logic       capture_pin,
    input wire logic       comparator_output,
    input wire logic       capture_irq_ack,
    input wire logic       overflow_irq_ack,
    input wire logic       capture_irq,
    input wire logic       overflow_irq,
    input wire logic       count_a,
    input wire logic       count_top
);
    logic [3:0] quiet;
    logic [3:0] next_quiet;
    logic       pin_q;
    logic       cmp_q;
    // Cycles since a source change or any write could cause a capture
    always_comb
    begin
        next_quiet = (quiet == 4'hF) ? quiet : quiet + 4'h1;
        if (capture_pin != pin_q || comparator_output != cmp_q || bus_wr)
            next_quiet = 4'h0;
    end
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            quiet <= 4'hF;
            pin_q <= 1'b0;
            cmp_q <= 1'b0;
        end
        else
        begin
            quiet <= next_quiet;
            pin_q <= capture_pin;
            cmp_q <= comparator_output;
        end
    end
    default clocking dc @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    rd_count_a_a: assert property (
        bus_rd && bus_addr == tcc_pkg::ADDR_CNT_LO && count_a |=> bus_rdata == 8'h00)
        else $error("counter read at count_a not zero");
    rdata_hold_a: assert property (!bus_rd |=> $stable(bus_rdata))
        else $error("read data moved without a read");
    unmapped_read_a: assert property (
        bus_rd && bus_addr > tcc_pkg::ADDR_CMP_CTRL |=> bus_rdata == 8'h00)
        else $error("unmapped read not zero");
    cnt_write_a: assert property (
        bus_wr && bus_addr == tcc_pkg::ADDR_CNT_LO && bus_wdata != 8'h00 |=> !count_a)
        else $error("counter low write lost");
    cap_rise_a: assert property ($rose(capture_irq) |-> quiet <= 4'hC)
        else $error("capture flag without a cause");
    cap_fall_a: assert property (
        $fell(capture_irq) |-> $past(capture_irq_ack) || $past(bus_wr))
        else $error("capture flag cleared without ack");
    ovf_fall_a: assert property (
        $fell(overflow_irq) |-> $past(overflow_irq_ack) || $past(bus_wr))
        else $error("overflow flag cleared without ack");
    ovf_rise_a: assert property (
        $rose(overflow_irq) |-> $past(count_top) || $past(count_a) || $past(bus_wr))
        else $error("overflow flag away from top or count_a");
endmodule
bind tcc_timer tcc_timer_chk u_chk
(
    .core_clk(core_clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .capture_pin(capture_pin), .comparator_output(comparator_output),
    .capture_irq_ack(capture_irq_ack), .overflow_irq_ack(overflow_irq_ack),
    .capture_irq(capture_irq), .overflow_irq(overflow_irq),
    .count_a(count_a), .count_top(count_top)
);

// *** sim/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    typedef struct packed {logic [15:0] val; logic bot; logic top;} tcc_row_t;
    tcc_row_t rows [4] = '{'{16'h0000, 1'b1, 1'b0}, '{16'hFFFF, 1'b0, 1'b1},
                           '{16'h01FF, 1'b0, 1'b0}, '{16'h8000, 1'b0, 1'b0}};
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        ext_pin = 1'b0;
    logic        cap_pin = 1'b0;
    logic        cmp_out = 1'b0;
    logic        cap_ack = 1'b0;
    logic        ovf_ack = 1'b0;
    logic        tick = 1'b0;
    logic [3:0]  bus_addr;
    logic        bus_wr;
    logic        bus_rd;
    logic [7:0]  bus_wdata;
    logic [7:0]  bus_rdata;
    logic        cap_irq;
    logic        ovf_irq;
    logic        count_a;
    logic        count_top;
    logic [15:0] v;
    logic [7:0]  b;
    int          n0;
    int          n1;
    int          fail_count = 0;
    int          cmp_count = 0;
    always #12.5 core_clk = ~core_clk;
    tcc_cpu_model cpu (.core_clk(core_clk), .bus_addr(bus_addr), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata));
    tcc_timer dut (.core_clk(core_clk), .rst_n(rst_n), .bus_addr(bus_addr),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .prescale_tick(tick), .external_count_pin(ext_pin), .capture_pin(cap_pin),
        .comparator_output(cmp_out), .capture_irq_ack(cap_ack), .overflow_irq_ack(ovf_ack),
        .capture_irq(cap_irq), .overflow_irq(ovf_irq), .count_a(count_a),
        .count_top(count_top));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Sets both sources, then waits a bounded time for the capture flag
    task automatic hit(input logic pin, input logic cmp, input logic exp, output int n);
        @(posedge core_clk);
        cap_pin <= pin;
        cmp_out <= cmp;
        n = 0;
        while (cap_irq !== 1'b1 && n < 40)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        check("cap_irq", {15'h0, cap_irq}, {15'h0, exp});
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        #100000;
        fail_count++;
        print_verdict();
    end
    initial
    begin
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        cpu.rd16(tcc_pkg::ADDR_CNT_LO, v);
        check("cnt_reset", v, tcc_pkg::CNT_RESET);
        cpu.rd16(tcc_pkg::ADDR_CAP_LO, v);
        check("cap_reset", v, tcc_pkg::CAP_RESET);
        $display("test reset done");
        foreach (rows[i])
        begin
            cpu.wr16(tcc_pkg::ADDR_CNT_LO, rows[i].val);
            cpu.rd16(tcc_pkg::ADDR_CNT_LO, v);
            check("cnt_rw", v, rows[i].val);
            check("bot_top", {14'h0, count_a, count_top}, {14'h0, rows[i].bot, rows[i].top});
        end
        cpu.wr(tcc_pkg::ADDR_CNT_HI, 8'h12);
        cpu.wr(tcc_pkg::ADDR_CNT_LO, 8'h34);
        cpu.wr(tcc_pkg::ADDR_CNT_LO, 8'h56);
        cpu.rd16(tcc_pkg::ADDR_CNT_LO, v);
        check("hold_reuse", v, 16'h1256);
        cpu.rd(4'h9, b);
        check("unmapped", {8'h00, b}, 16'h0000);
        $display("test counter access done");
        // Two enabled clock edges take the count across the top
        cpu.wr(tcc_pkg::ADDR_IRQ_MASK, 8'h21);
        cpu.wr16(tcc_pkg::ADDR_CNT_LO, 16'hFFFE);
        cpu.wr(tcc_pkg::ADDR_CTRL_B, {5'h00, tcc_pkg::CS_DIRECT});
        cpu.wr(tcc_pkg::ADDR_CTRL_B, {5'h00, tcc_pkg::CS_NONE});
        cpu.rd16(tcc_pkg::ADDR_CNT_LO, v);
        check("cnt_wrap", v, 16'h0000);
        check("ovf_irq", {15'h0, ovf_irq}, 16'h0001);
        cpu.rd(tcc_pkg::ADDR_FLAGS, b);
        check("flags", {8'h00, b}, 16'h0001);
        @(posedge core_clk);
        ovf_ack <= 1'b1;
        @(posedge core_clk);
        ovf_ack <= 1'b0;
        @(negedge core_clk);
        check("ovf_ack", {15'h0, ovf_irq}, 16'h0000);
        $display("test overflow done");
        // One rising pin edge, then one prescaler tick, each count once
        cpu.wr(tcc_pkg::ADDR_CTRL_B, {5'h00, tcc_pkg::CS_EXT_RISE});
        @(posedge core_clk);
        ext_pin <= 1'b1;
        repeat (6) @(posedge core_clk);
        ext_pin <= 1'b0;
        cpu.wr(tcc_pkg::ADDR_CTRL_B, 8'h02);
        @(posedge core_clk);
        tick <= 1'b1;
        @(posedge core_clk);
        tick <= 1'b0;
        cpu.wr(tcc_pkg::ADDR_CTRL_B, {5'h00, tcc_pkg::CS_NONE});
        cpu.rd16(tcc_pkg::ADDR_CNT_LO, v);
        check("ext_tick", v, 16'h0002);
        $display("test clock sources done");
        cpu.wr16(tcc_pkg::ADDR_CNT_LO, 16'h1234);
        cpu.wr(tcc_pkg::ADDR_CTRL_B, 8'h40);
        hit(1'b1, 1'b0, 1'b1, n0);
        cpu.rd16(tcc_pkg::ADDR_CAP_LO, v);
        check("cap_val", v, 16'h1234);
        cpu.wr(tcc_pkg::ADDR_FLAGS, 8'h20);
        check("cap_clr", {15'h0, cap_irq}, 16'h0000);
        cpu.wr16(tcc_pkg::ADDR_CNT_LO, 16'h2345);
        hit(1'b0, 1'b0, 1'b0, n1);
        hit(1'b1, 1'b0, 1'b1, n1);
        @(posedge core_clk);
        cap_ack <= 1'b1;
        @(posedge core_clk);
        cap_ack <= 1'b0;
        cpu.wr16(tcc_pkg::ADDR_CNT_LO, 16'h3456);
        hit(1'b0, 1'b0, 1'b0, n1);
        hit(1'b1, 1'b0, 1'b1, n1);
        cpu.rd16(tcc_pkg::ADDR_CAP_LO, v);
        check("cap_over", v, 16'h3456);
        cpu.wr(tcc_pkg::ADDR_CTRL_B, 8'h00);
        cpu.wr(tcc_pkg::ADDR_FLAGS, 8'h20);
        hit(1'b0, 1'b0, 1'b1, n1);
        $display("test capture done");
        cpu.wr(tcc_pkg::ADDR_FLAGS, 8'h20);
        cpu.wr(tcc_pkg::ADDR_CTRL_B, 8'hC0);
        hit(1'b0, 1'b0, 1'b0, n1);
        hit(1'b1, 1'b0, 1'b1, n1);
        check("filt_delay", 16'(n1 - n0), 16'(tcc_pkg::FILT_SAMPLES));
        cpu.wr(tcc_pkg::ADDR_FLAGS, 8'h20);
        @(posedge core_clk);
        cap_pin <= 1'b0;
        repeat (2) @(posedge core_clk);
        hit(1'b1, 1'b0, 1'b0, n1);
        $display("test filter done");
        cpu.wr(tcc_pkg::ADDR_CTRL_B, 8'h40);
        cpu.wr(tcc_pkg::ADDR_CMP_CTRL, 8'h04);
        repeat (12) @(posedge core_clk);
        cpu.wr(tcc_pkg::ADDR_FLAGS, 8'h20);
        cpu.wr16(tcc_pkg::ADDR_CNT_LO, 16'h4567);
        hit(1'b0, 1'b0, 1'b0, n1);
        hit(1'b1, 1'b0, 1'b0, n1);
        hit(1'b1, 1'b1, 1'b1, n1);
        cpu.wr(tcc_pkg::ADDR_CMP_CTRL, 8'h00);
        cpu.wr16(tcc_pkg::ADDR_CAP_LO, 16'hBEEF);
        cpu.rd16(tcc_pkg::ADDR_CAP_LO, v);
        check("cap_cmp", v, 16'h4567);
        cpu.wr(tcc_pkg::ADDR_CTRL_B, 8'h58);
        cpu.wr16(tcc_pkg::ADDR_CAP_LO, 16'h1111);
        cpu.rd16(tcc_pkg::ADDR_CAP_LO, v);
        check("cap_top_wr", v, 16'h1111);
        cpu.wr16(tcc_pkg::ADDR_CNT_LO, 16'h1111);
        check("cap_top", {15'h0, count_top}, 16'h0001);
        cpu.wr(tcc_pkg::ADDR_FLAGS, 8'h20);
        hit(1'b0, 1'b0, 1'b0, n1);
        hit(1'b1, 1'b0, 1'b0, n1);
        $display("test source and mode done");
        // Top of 2 from 1: up, down, down, up; overflow at count_a
        cpu.wr(tcc_pkg::ADDR_CTRL_B, 8'h10);
        cpu.wr16(tcc_pkg::ADDR_CAP_LO, 16'h0002);
        cpu.wr16(tcc_pkg::ADDR_CNT_LO, 16'h0001);
        repeat (2)
        begin
            cpu.wr(tcc_pkg::ADDR_CTRL_B, 8'h11);
            cpu.wr(tcc_pkg::ADDR_CTRL_B, 8'h10);
        end
        cpu.rd16(tcc_pkg::ADDR_CNT_LO, v);
        check("dual_slope", v, 16'h0001);
        check("dual_ovf", {15'h0, ovf_irq}, 16'h0001);
        $display("test dual slope done");
        print_verdict();
    end
endmodule

// *** src/tcc_pkg.sv ***
package tcc_pkg;
    // Register addresses on the 8-bit internal bus
    localparam logic [3:0] ADDR_CTRL_A     = 4'h0;
    localparam logic [3:0] ADDR_CTRL_B     = 4'h1;
    localparam logic [3:0] ADDR_CNT_LO     = 4'h2;
    localparam logic [3:0] ADDR_CNT_HI     = 4'h3;
    localparam logic [3:0] ADDR_CAP_LO     = 4'h4;
    localparam logic [3:0] ADDR_CAP_HI     = 4'h5;
    localparam logic [3:0] ADDR_IRQ_MASK   = 4'h6;
    localparam logic [3:0] ADDR_FLAGS      = 4'h7;
    localparam logic [3:0] ADDR_CMP_CTRL   = 4'h8;
    // Field positions
    localparam int CTRL_B_CS_LO      = 0;
    localparam int CTRL_B_WGM_HI_LO  = 3;
    localparam int CTRL_B_EDGE       = 6;
    localparam int CTRL_B_FILT       = 7;
    localparam int FLAG_OVF          = 0;
    localparam int FLAG_CAP          = 5;
    localparam int CMP_CTRL_SEL      = 2;
    localparam int CMP_CTRL_OUT      = 5;
    // Clock select codes
    localparam logic [2:0] CS_NONE     = 3'h0;
    localparam logic [2:0] CS_DIRECT   = 3'h1;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    // Waveform modes; all but WGM_NORMAL use the capture register as top
    localparam logic [3:0] WGM_PFC_CAP  = 4'h8;
    localparam logic [3:0] WGM_PC_CAP   = 4'hA;
    localparam logic [3:0] WGM_CTC_CAP  = 4'hC;
    localparam logic [3:0] WGM_FAST_CAP = 4'hE;
    localparam logic [3:0] WGM_NORMAL   = 4'h0;
    // Counter limits, reset values and filter sample count
    localparam logic [15:0] CNT_MAX     = 16'hFFFF;
    localparam logic [15:0] CNT_RESET   = 16'h0000;
    localparam logic [15:0] CAP_RESET   = 16'h0000;
    localparam logic [7:0]  REG_RESET   = 8'h00;
    localparam int          FILT_SAMPLES = 4;
endpackage

// *** src/tcc_timer.sv ***
`timescale 1ns/1ps
// Functional notes
// - Clock select zero stops counter
// - Counter high via holding register
// - Counter clears, increments or decrements
// - Count_a at zero, top at sequence maximum
// - CPU write beats count or clear
// - Mode field split across control registers
// - Overflow flag set per waveform mode
// - Matching edge copies counter into capture
// - Capture flag set with capture store
// - Capture flag interrupt, cleared by ack/one
// - Capture low read loads holding register
// - Capture writable only in capture-top modes
// - Select bit picks comparator as source
// - Source switch may capture; clear flag
// - Inputs synchronized like external clock pin
// - Filter changes after four agreeing samples
// - Filter on system clock adds four
// - Capture input off in capture-top modes
// - Port-driven pin level triggers capture
// - New capture overwrites unread value
// - One holding register shared by all
// - Top is all ones or register
module tcc_timer
(
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic [3:0] bus_addr,
    input  wire logic       bus_wr,
    input  wire logic       bus_rd,
    input  wire logic [7:0] bus_wdata,
    output logic      [7:0] bus_rdata,
    input  wire logic       prescale_tick,
    input  wire logic       external_count_pin,
    input  wire logic       capture_pin,
    input  wire logic       comparator_output,
    input  wire logic       capture_irq_ack,
    input  wire logic       overflow_irq_ack,
    output logic            capture_irq,
    output logic            overflow_irq,
    output logic            count_a,
    output logic            count_top
);
    logic [1:0]  rst_sync;
    logic        rst_int_n;
    logic [7:0]  control_register_a;
    logic [7:0]  control_register_b;
    logic [7:0]  timer_irq_mask_register;
    logic        comparator_capture_select;
    logic [15:0] counter_value;
    logic [15:0] capture_value;
    logic [7:0]  hold_byte;
    logic        overflow_flag;
    logic        capture_flag;
    logic        count_down;
    logic [2:0]  ext_sync;
    logic [2:0]  cap_sync;
    logic [2:0]  cmp_sync;
    logic [2:0]  filt_hist;
    logic        filt_out;
    logic        edge_prev;
    logic [7:0]  next_control_register_a;
    logic [7:0]  next_control_register_b;
    logic [7:0]  next_timer_irq_mask_register;
    logic        next_comparator_capture_select;
    logic [15:0] next_counter_value;
    logic [15:0] next_capture_value;
    logic [7:0]  next_hold_byte;
    logic        next_overflow_flag;
    logic        next_capture_flag;
    logic        next_count_down;
    logic [2:0]  next_filt_hist;
    logic        next_filt_out;
    logic        next_edge_prev;
    logic [7:0]  next_bus_rdata;
    logic [3:0]  waveform_mode_field;
    logic [2:0]  clock_select;
    logic        noise_filter_enable;
    logic        capture_edge_select;
    logic        capture_irq_enable;
    logic        overflow_irq_enable;
    logic        timer_clock;
    logic        cap_top_mode;
    logic [15:0] top_value;
    logic        dual_slope;
    logic        cap_src;
    logic        edge_in;
    logic        capture_event;
    logic        wr_cnt_lo;
    logic        wr_cap_lo;
    logic        wr_flags;

    // Reset released through two flops
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            rst_sync <= 2'h0;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_int_n = rst_sync[1];

    assign waveform_mode_field = {control_register_b[tcc_pkg::CTRL_B_WGM_HI_LO +: 2],
                                  control_register_a[1:0]};
    assign clock_select        = control_register_b[tcc_pkg::CTRL_B_CS_LO +: 3];
    assign noise_filter_enable = control_register_b[tcc_pkg::CTRL_B_FILT];
    assign capture_edge_select = control_register_b[tcc_pkg::CTRL_B_EDGE];
    assign capture_irq_enable  = timer_irq_mask_register[tcc_pkg::FLAG_CAP];
    assign overflow_irq_enable = timer_irq_mask_register[tcc_pkg::FLAG_OVF];
    assign cap_top_mode = (waveform_mode_field == tcc_pkg::WGM_PFC_CAP)
                        | (waveform_mode_field == tcc_pkg::WGM_PC_CAP)
                        | (waveform_mode_field == tcc_pkg::WGM_CTC_CAP)
                        | (waveform_mode_field == tcc_pkg::WGM_FAST_CAP);
    // fixed maximum or capture register as top
    assign top_value  = cap_top_mode ? capture_value : tcc_pkg::CNT_MAX;
    assign dual_slope = (waveform_mode_field == tcc_pkg::WGM_PFC_CAP)
                      | (waveform_mode_field == tcc_pkg::WGM_PC_CAP);
    assign count_a   = (counter_value == tcc_pkg::CNT_RESET);
    assign count_top = (counter_value == top_value);

    // clock source choice; zero stops the counter
    always_comb
    begin
        case (clock_select)
            tcc_pkg::CS_NONE:     timer_clock = 1'b0;
            tcc_pkg::CS_DIRECT:   timer_clock = 1'b1;
            tcc_pkg::CS_EXT_FALL: timer_clock = ext_sync[2] & ~ext_sync[1];
            tcc_pkg::CS_EXT_RISE: timer_clock = ~ext_sync[2] & ext_sync[1];
            default:              timer_clock = prescale_tick;
        endcase
    end

    // same sampler for every pin input
    assign cap_src = comparator_capture_select ? cmp_sync[2] : cap_sync[2];

    assign wr_cnt_lo = bus_wr & (bus_addr == tcc_pkg::ADDR_CNT_LO);
    assign wr_cap_lo = bus_wr & (bus_addr == tcc_pkg::ADDR_CAP_LO);
    assign wr_flags  = bus_wr & (bus_addr == tcc_pkg::ADDR_FLAGS);

    // Filter and edge detector
    always_comb
    begin
        next_filt_hist = {filt_hist[1:0], cap_src};
        next_filt_out  = filt_out;
        // three held samples plus the live one must agree
        // Using the live sample keeps the added delay at four cycles, not five
        if (&{filt_hist, cap_src})
            next_filt_out = 1'b1;
        else if (~|{filt_hist, cap_src})
            next_filt_out = 1'b0;
        // filtered path adds the sample window delay
        edge_in = noise_filter_enable ? filt_out : cap_src;
        next_edge_prev = edge_in;
        // detector idle while capture holds top; pin level drives it
        // rising when edge select set, else falling
        capture_event = !cap_top_mode &&
            (capture_edge_select ? (edge_in & ~edge_prev) : (~edge_in & edge_prev));
    end

    // Counter, capture, flags and register file
    always_comb
    begin
        next_control_register_a        = control_register_a;
        next_control_register_b        = control_register_b;
        next_timer_irq_mask_register   = timer_irq_mask_register;
        next_comparator_capture_select = comparator_capture_select;
        next_counter_value             = counter_value;
        next_capture_value             = capture_value;
        next_hold_byte                 = hold_byte;
        next_overflow_flag             = overflow_flag;
        next_capture_flag              = capture_flag;
        next_count_down                = count_down;
        next_bus_rdata                 = bus_rdata;
        if (!dual_slope)
            next_count_down = 1'b0;
        // count per mode on each timer clock
        if (timer_clock)
        begin
            if (dual_slope)
            begin
                if (count_down ? count_a : count_top)
                    next_count_down = ~count_down;
                next_counter_value = (count_down && !count_a) || (!count_down && count_top)
                                   ? counter_value - 16'h0001 : counter_value + 16'h0001;
                if (count_down && count_a)
                begin
                    next_overflow_flag = 1'b1;
                    next_counter_value = counter_value + 16'h0001;
                end
            end
            else if (count_top)
            begin
                next_counter_value = tcc_pkg::CNT_RESET;
                // single slope overflows at maximum only or at top
                if (waveform_mode_field != tcc_pkg::WGM_CTC_CAP || counter_value == tcc_pkg::CNT_MAX)
                    next_overflow_flag = 1'b1;
            end
            else
                next_counter_value = counter_value + 16'h0001;
        end
        // each event overwrites the capture register
        // store counter on a matching edge
        if (capture_event)
            next_capture_value = counter_value;
        // Writes; a counter write overrides counting
        if (bus_wr)
        begin
            case (bus_addr)
                tcc_pkg::ADDR_CTRL_A:   next_control_register_a = bus_wdata;
                tcc_pkg::ADDR_CTRL_B:   next_control_register_b = bus_wdata;
                tcc_pkg::ADDR_IRQ_MASK: next_timer_irq_mask_register = bus_wdata;
                tcc_pkg::ADDR_CMP_CTRL:
                    next_comparator_capture_select = bus_wdata[tcc_pkg::CMP_CTRL_SEL];
                // high byte locations reach the holding register
                // one holding byte for every wide register
                tcc_pkg::ADDR_CNT_HI,
                tcc_pkg::ADDR_CAP_HI:   next_hold_byte = bus_wdata;
                // holding byte kept, so low writes may repeat
                tcc_pkg::ADDR_CNT_LO:   next_counter_value = {hold_byte, bus_wdata};
                // capture write only in capture-top modes
                tcc_pkg::ADDR_CAP_LO:
                    if (cap_top_mode)
                        next_capture_value = {hold_byte, bus_wdata};
                default: ;
            endcase
        end
        // clear by acknowledge or write of one; use this clear
        if (capture_irq_ack || (wr_flags && bus_wdata[tcc_pkg::FLAG_CAP]))
            next_capture_flag = 1'b0;
        if (overflow_irq_ack || (wr_flags && bus_wdata[tcc_pkg::FLAG_OVF]))
            next_overflow_flag = 1'b0;
        // flag set with the store, winning over a clear
        if (capture_event)
            next_capture_flag = 1'b1;
        if (timer_clock && !wr_cnt_lo && (dual_slope ? (count_down && count_a) :
            (count_top && (waveform_mode_field != tcc_pkg::WGM_CTC_CAP
                           || counter_value == tcc_pkg::CNT_MAX))))
            next_overflow_flag = 1'b1;
        // Reads
        if (bus_rd)
        begin
            case (bus_addr)
                tcc_pkg::ADDR_CTRL_A:   next_bus_rdata = control_register_a;
                tcc_pkg::ADDR_CTRL_B:   next_bus_rdata = control_register_b;
                tcc_pkg::ADDR_IRQ_MASK: next_bus_rdata = timer_irq_mask_register;
                tcc_pkg::ADDR_FLAGS:
                    next_bus_rdata = {2'h0, capture_flag, 4'h0, overflow_flag};
                tcc_pkg::ADDR_CMP_CTRL:
                    next_bus_rdata = {2'h0, cmp_sync[2], 2'h0, comparator_capture_select, 2'h0};
                tcc_pkg::ADDR_CNT_HI,
                tcc_pkg::ADDR_CAP_HI:   next_bus_rdata = hold_byte;
                // low read latches counter upper byte
                tcc_pkg::ADDR_CNT_LO:
                begin
                    next_bus_rdata = counter_value[7:0];
                    next_hold_byte = counter_value[15:8];
                end
                // low read latches capture upper byte
                tcc_pkg::ADDR_CAP_LO:
                begin
                    next_bus_rdata = capture_value[7:0];
                    next_hold_byte = capture_value[15:8];
                end
                default:                next_bus_rdata = tcc_pkg::REG_RESET;
            endcase
        end
    end

    assign capture_irq  = capture_flag & capture_irq_enable;
    assign overflow_irq = overflow_flag & overflow_irq_enable;

    always_ff @(posedge core_clk or negedge rst_int_n)
    begin
        if (!rst_int_n)
        begin
            control_register_a        <= tcc_pkg::REG_RESET;
            control_register_b        <= tcc_pkg::REG_RESET;
            timer_irq_mask_register   <= tcc_pkg::REG_RESET;
            comparator_capture_select <= 1'b0;
            counter_value             <= tcc_pkg::CNT_RESET;
            capture_value             <= tcc_pkg::CAP_RESET;
            hold_byte                 <= tcc_pkg::REG_RESET;
            overflow_flag             <= 1'b0;
            capture_flag              <= 1'b0;
            count_down                <= 1'b0;
            ext_sync                  <= 3'h0;
            cap_sync                  <= 3'h0;
            cmp_sync                  <= 3'h0;
            filt_hist                 <= 3'h0;
            filt_out                  <= 1'b0;
            edge_prev                 <= 1'b0;
            bus_rdata                 <= tcc_pkg::REG_RESET;
        end
        else
        begin
            control_register_a        <= next_control_register_a;
            control_register_b        <= next_control_register_b;
            timer_irq_mask_register   <= next_timer_irq_mask_register;
            comparator_capture_select <= next_comparator_capture_select;
            counter_value             <= next_counter_value;
            capture_value             <= next_capture_value;
            hold_byte                 <= next_hold_byte;
            overflow_flag             <= next_overflow_flag;
            capture_flag              <= next_capture_flag;
            count_down                <= next_count_down;
            // Bit 2 is an edge-detect history stage after two sync flops in ext_sync; in cap_sync and cmp_sync it is a third stage feeding cap_src
            ext_sync                  <= {ext_sync[1:0], external_count_pin};
            cap_sync                  <= {cap_sync[1:0], capture_pin};
            cmp_sync                  <= {cmp_sync[1:0], comparator_output};
            filt_hist                 <= next_filt_hist;
            filt_out                  <= next_filt_out;
            edge_prev                 <= next_edge_prev;
            bus_rdata                 <= next_bus_rdata;
        end
    end
endmodule
